// [common/modsynth_pkg.sv]
// Constants, register map and carrier types for the modulator/synthesizer config bank
// Operation
// - Reset-control register at 0x00, resets 0x0000
// - Bit 0 write-only soft-reset trigger
// - Block-enable register at 0x01, resets 0xF67F
// - Bit 11 enables direct oscillator LO path
// - Bit 10 enables modulator and LO chain
// - Bit 9 enables quadrature divider
// - Bit 8 enables pre-divider external LO driver
// - Bit 7 enables post-divider external LO driver
// - Bits 6..1 enable six blocks, reset one
package modsynth_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NREG   = 18;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int IDX_W  = 5;

  localparam logic [IDX_W-1:0] IDX_RESET_TRIG = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ENABLES    = 5'h01;
  localparam int               TRIGGER_BIT    = 0;

  // Index order: reset trigger, enables, int, frac, modulus, override mask,
  // pump, detector, oscillator, transformer, linearity, phase/polarity,
  // offset, detector timing, dither setup, dither seed, band, calibration
  localparam logic [NREG-1:0][ADDR_W-1:0] REG_ADDR = {
    7'h49, 7'h45, 7'h43, 7'h42, 7'h40, 7'h33, 7'h32, 7'h31, 7'h30,
    7'h22, 7'h21, 7'h20, 7'h10, 7'h04, 7'h03, 7'h02, 7'h01, 7'h00};

  localparam logic [NREG-1:0][DATA_W-1:0] REG_RESET = {
    16'h16bd, 16'h0000, 16'h0000, 16'h000e, 16'h0010, 16'h0000,
    16'h0900, 16'h1101, 16'h0000, 16'h2a03, 16'h000b, 16'h0c26,
    16'hf67f, 16'h0600, 16'h0128, 16'h002c, 16'hf67f, 16'h0000};

  // Writable bits; the trigger stores nothing
  localparam logic [NREG-1:0][DATA_W-1:0] REG_WMASK = {
    16'h3fff, 16'h3fff, 16'hffff, 16'h000f, 16'h007f, 16'hffff,
    16'h7fff, 16'h1fff, 16'h00ff, 16'hffff, 16'h007f, 16'h7c3f,
    16'h0ffe, 16'hffff, 16'hffff, 16'h0fff, 16'h0ffe, 16'h0000};

  // ****************************************
  // Block-enable field positions
  // ****************************************
  localparam int EN_VCO_DIRECT_LO = 11;
  localparam int EN_MOD_CHAIN     = 10;
  localparam int EN_QUAD_DIV      = 9;
  localparam int EN_EXT_LO_PRE    = 8;
  localparam int EN_EXT_LO_POST   = 7;
  localparam int EN_OSC_MUX       = 6;
  localparam int EN_REF_BUF       = 5;
  localparam int EN_OSC           = 4;
  localparam int EN_OSC_DIV       = 3;
  localparam int EN_PUMP          = 2;
  localparam int EN_OSC_REG       = 1;

  // ****************************************
  // Serial frame timing
  // ****************************************
  localparam logic [4:0] HDR_LAST  = 5'd7;
  localparam logic [4:0] DATA_LAST = 5'd15;
  localparam logic [4:0] DATA_BITS = 5'd16;

  typedef struct packed {
    logic vco_direct_lo_enable;
    logic modulator_chain_enable;
    logic quadrature_divider_enable;
    logic ext_lo_pre_divider_drive;
    logic ext_lo_post_divider_drive;
    logic oscillator_mux_on;
    logic reference_buffer_on;
    logic oscillators_on;
    logic oscillator_dividers_on;
    logic charge_pump_on;
    logic oscillator_regulator_on;
  } block_enables_t;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    SP_IDLE, SP_HEADER, SP_WDATA, SP_RDATA, SP_HOLD
  } spi_state_t;

  // Hit flag on top, register index below
  function automatic logic [IDX_W:0] addr_lookup(input logic [ADDR_W-1:0] a);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADDR[i] == a) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction : addr_lookup

  function automatic block_enables_t decode_enables(input logic [DATA_W-1:0] w);
    block_enables_t e;
    e.vco_direct_lo_enable      = w[EN_VCO_DIRECT_LO];
    e.modulator_chain_enable    = w[EN_MOD_CHAIN];
    e.quadrature_divider_enable = w[EN_QUAD_DIV];
    e.ext_lo_pre_divider_drive  = w[EN_EXT_LO_PRE];
    e.ext_lo_post_divider_drive = w[EN_EXT_LO_POST];
    e.oscillator_mux_on         = w[EN_OSC_MUX];
    e.reference_buffer_on       = w[EN_REF_BUF];
    e.oscillators_on            = w[EN_OSC];
    e.oscillator_dividers_on    = w[EN_OSC_DIV];
    e.charge_pump_on            = w[EN_PUMP];
    e.oscillator_regulator_on   = w[EN_OSC_REG];
    return e;
  endfunction : decode_enables

endpackage : modsynth_pkg

// [rtl/modsynth_reg_store.sv]
// Register storage with reset values, write masking and registered read
`timescale 1ns/1ps
`default_nettype none
module modsynth_reg_store
  import modsynth_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         soft_clr,
  input  wire reg_write_t                   wr,
  input  wire logic                         rd_hit,
  input  wire logic [IDX_W-1:0]             rd_idx,
  output logic      [DATA_W-1:0]            rd_data_q,
  output logic      [NREG-1:0][DATA_W-1:0]  regs_q
);

  // ****************************************
  // Write merge
  // ****************************************
  wire logic [DATA_W-1:0] wmask   = REG_WMASK[wr.idx];
  wire logic [DATA_W-1:0] wmerged = (wr.data & wmask) | (REG_RESET[wr.idx] & ~wmask);
  wire logic              rd_wo   = (rd_idx == IDX_RESET_TRIG);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs_q <= REG_RESET;
    end else if (soft_clr) begin
      regs_q <= REG_RESET;
    end else if (wr.en) begin
      regs_q[wr.idx] <= wmerged;
    end
  end

  // Trigger register is write-only and unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= (rd_hit && !rd_wo) ? regs_q[rd_idx] : '0;
    end
  end

endmodule : modsynth_reg_store
`default_nettype wire

// [rtl/modsynth_cfg_top.sv]
// Serial-port configuration bank of the modulator/synthesizer
`timescale 1ns/1ps
`default_nettype none
module modsynth_cfg_top
  import modsynth_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        spi_clk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_data_in,
  output logic                             spi_data_out,
  output logic                             spi_data_oe,
  output block_enables_t                   block_enables,
  output logic     [NREG-1:0][DATA_W-1:0]  cfg_words
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Serial clock must run at most mclk/8 so each edge is seen
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] din_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= '0;
      cs_q   <= 2'b11;
      din_q  <= '0;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_clk};
      cs_q   <= {cs_q[0], spi_cs_n};
      din_q  <= {din_q[0], spi_data_in};
    end
  end

  wire logic sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire logic sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire logic cs_idle   = cs_q[1];
  wire logic din       = din_q[1];

  // ****************************************
  // Frame state
  // ****************************************
  spi_state_t         state_q;
  spi_state_t         state_d;
  logic [4:0]         cnt_q;
  logic [4:0]         cnt_d;
  logic [DATA_W-1:0]  sh_q;
  logic [DATA_W-1:0]  sh_d;
  logic [IDX_W-1:0]   idx_q;
  logic               hit_q;
  logic               out_q;
  logic               oe_q;
  logic               out_d;
  logic               oe_d;
  reg_write_t         wr_q;
  reg_write_t         wr_d;
  logic               clr_q;
  logic               clr_d;
  block_enables_t     enables_q;
  logic [DATA_W-1:0]  rd_data;

  // Header is read/write bit then seven address bits, MSB first
  wire logic [7:0]       header   = {sh_q[6:0], din};
  wire logic [IDX_W:0]   lookup   = addr_lookup(header[6:0]);
  wire logic [DATA_W-1:0] wdata   = {sh_q[14:0], din};
  wire logic             hdr_done = sclk_rise && (cnt_q == HDR_LAST);
  wire logic             dat_done = sclk_rise && (cnt_q == DATA_LAST);
  wire logic             trig_hit = (idx_q == IDX_RESET_TRIG) && wdata[TRIGGER_BIT];

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    out_d   = out_q;
    oe_d    = oe_q;
    wr_d    = '0;
    clr_d   = 1'b0;
    if (cs_idle) begin
      state_d = SP_IDLE;
      cnt_d   = '0;
      oe_d    = 1'b0;
      out_d   = 1'b0;
    end else begin
      unique case (state_q)
        SP_IDLE: begin
          state_d = SP_HEADER;
          cnt_d   = '0;
        end
        SP_HEADER: begin
          if (hdr_done) begin
            cnt_d   = '0;
            state_d = header[7] ? SP_RDATA : SP_WDATA;
          end else if (sclk_rise) begin
            sh_d  = {sh_q[14:0], din};
            cnt_d = cnt_q + 5'd1;
          end
        end
        SP_WDATA: begin
          if (dat_done) begin
            state_d  = SP_HOLD;
            // Unmapped writes vanish
            wr_d.en   = hit_q;
            wr_d.idx  = idx_q;
            wr_d.data = wdata;
            clr_d     = hit_q && trig_hit;
          end else if (sclk_rise) begin
            sh_d  = {sh_q[14:0], din};
            cnt_d = cnt_q + 5'd1;
          end
        end
        SP_RDATA: begin
          if (sclk_fall && cnt_q == '0) begin
            out_d = rd_data[DATA_W-1];
            oe_d  = 1'b1;
            sh_d  = {rd_data[DATA_W-2:0], 1'b0};
            cnt_d = 5'd1;
          end else if (sclk_fall && cnt_q != DATA_BITS) begin
            out_d = sh_q[DATA_W-1];
            sh_d  = {sh_q[DATA_W-2:0], 1'b0};
            cnt_d = cnt_q + 5'd1;
          end
        end
        SP_HOLD: begin
          state_d = SP_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SP_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      out_q   <= 1'b0;
      oe_q    <= 1'b0;
      wr_q    <= '0;
      clr_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      out_q   <= out_d;
      oe_q    <= oe_d;
      wr_q    <= wr_d;
      clr_q   <= clr_d;
    end
  end

  // Address latched at end of header; read word is ready long before first fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= '0;
      hit_q <= 1'b0;
    end else if (state_q == SP_HEADER && hdr_done) begin
      idx_q <= lookup[IDX_W-1:0];
      hit_q <= lookup[IDX_W];
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  modsynth_reg_store u_store (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .soft_clr  (clr_q),
    .wr        (wr_q),
    .rd_hit    (hit_q),
    .rd_idx    (idx_q),
    .rd_data_q (rd_data),
    .regs_q    (cfg_words)
  );

  // ****************************************
  // Block enables
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enables_q <= decode_enables(REG_RESET[IDX_ENABLES]);
    end else begin
      enables_q <= decode_enables(cfg_words[IDX_ENABLES]);
    end
  end

  assign block_enables = enables_q;
  assign spi_data_out  = out_q;
  assign spi_data_oe   = oe_q;

endmodule : modsynth_cfg_top
`default_nettype wire

// [tb/modsynth_cfg_monitor.sv]
// Port-level checker for the config bank
`timescale 1ns/1ps
`default_nettype none
module modsynth_cfg_monitor
  import modsynth_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           rst_n,
  input wire logic                           spi_clk,
  input wire logic                           spi_cs_n,
  input wire logic                           spi_data_in,
  input wire logic                           spi_data_out,
  input wire logic                           spi_data_oe,
  input wire block_enables_t                 block_enables,
  input wire logic [NREG-1:0][DATA_W-1:0]    cfg_words
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Long enough to cover synchroniser and commit latency
  sequence cs_idle;
    spi_cs_n [*6];
  endsequence
  chk_trig_zero: assert property (cfg_words[0] == 16'h0000)
    else $error("trigger register holds a value");
  chk_rst_values: assert property ($rose(rst_n) |-> cfg_words[1] == 16'hf67f)
    else $error("enable register wrong after reset");
  chk_en_decode: assert property (block_enables == $past(cfg_words[1][11:1]))
    else $error("block enables do not follow register");
  chk_en_rsv: assert property (cfg_words[1][15:12] == 4'hf && cfg_words[1][0] == 1'b1)
    else $error("enable register reserved bits changed");
  chk_rsv_bits: assert property (cfg_words[7][15:7] == 9'h000 && cfg_words[9][15:8] == 8'h00)
    else $error("reserved bits not zero");
  chk_no_spont: assert property (cs_idle |=> $stable(cfg_words))
    else $error("register changed without a frame");
  chk_oe_idle: assert property (cs_idle |-> !spi_data_oe)
    else $error("data pin driven outside a frame");
  chk_oe_start: assert property ($rose(spi_data_oe) |-> !$past(spi_cs_n, 4))
    else $error("data pin driven without select");
  chk_oe_release: assert property ($fell(spi_data_oe) |-> $past(spi_cs_n, 3))
    else $error("data pin released early");
endmodule : modsynth_cfg_monitor

bind modsynth_cfg_top modsynth_cfg_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .spi_clk(spi_clk),
  .spi_cs_n(spi_cs_n), .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
  .spi_data_oe(spi_data_oe), .block_enables(block_enables), .cfg_words(cfg_words));
`default_nettype wire

// [tb/modsynth_host_model.sv]
// Host controller model driving serial frames
`timescale 1ns/1ps
`default_nettype none
module modsynth_host_model (
  input  wire logic mclk,
  output var  logic spi_clk,
  output var  logic spi_cs_n,
  output var  logic host_d,
  input  wire logic data_pin
);
  // ****************************************
  // Frame driver
  // ****************************************
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    host_d = 1'b0;
  end
  // Clock idles low between frames; half period 5 mclk
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] f;
    f = {rw, a, wd};
    rd = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (5) @(negedge mclk);
      spi_clk = 1'b0;
      // Released pin toggles so a stale level never passes
      host_d = (rw && i < 16) ? ~host_d : f[i];
      repeat (5) @(negedge mclk);
      if (rw && i < 16) rd[i] = data_pin;
      spi_clk = 1'b1;
    end
    repeat (5) @(negedge mclk);
    spi_clk = 1'b0;
    repeat (6) @(negedge mclk);
    spi_cs_n = 1'b1;
    // Gap long enough for the idle-select checks to see a quiet port
    repeat (8) @(negedge mclk);
  endtask : xfer
endmodule : modsynth_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import modsynth_pkg::*;
  logic                        mclk;
  logic                        rst_n;
  logic                        spi_clk;
  logic                        spi_cs_n;
  logic                        host_d;
  logic                        spi_data_out;
  logic                        spi_data_oe;
  logic                        data_pin;
  block_enables_t              block_enables;
  logic [NREG-1:0][DATA_W-1:0] cfg_words;
  int                          n_mismatch;
  int                          compares;
  // ****************************************
  // Harness
  // ****************************************
  assign data_pin = spi_data_oe ? spi_data_out : host_d;
  always #4 mclk = ~mclk;
  modsynth_cfg_top DUT (.mclk(mclk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_data_in(data_pin), .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
    .block_enables(block_enables), .cfg_words(cfg_words));
  modsynth_host_model host (.mclk(mclk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .host_d(host_d), .data_pin(data_pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.xfer(1'b1, a, 16'h0000, v);
    chk(v, exp);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] v;
    host.xfer(1'b0, a, d, v);
  endtask : wr
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ****************************************
  // Tests
  // ****************************************
  // About 50 frames of under 300 mclk each
  initial begin
    #300us;
    n_mismatch++;
    end_sim;
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < NREG; i++) begin
      rd(REG_ADDR[i], REG_RESET[i]);
      chk(cfg_words[i], REG_RESET[i]);
    end
    chk({5'h00, block_enables}, 16'h033f);
    $display("test reset values done");
    for (int b = 1; b < 12; b++) begin
      wr(7'h01, 16'h0001 << b);
      rd(7'h01, (16'h0001 << b) | 16'hf001);
      chk({5'h00, block_enables}, 16'h0001 << (b - 1));
    end
    $display("test walking enables done");
    wr(7'h21, 16'hffff);
    rd(7'h21, 16'h007f);
    wr(7'h05, 16'hffff);
    rd(7'h05, 16'h0000);
    rd(7'h00, 16'h0000);
    $display("test reserved bits done");
    wr(7'h02, 16'h0abc);
    wr(7'h00, 16'h0000);
    rd(7'h02, 16'h0abc);
    wr(7'h00, 16'h0001);
    rd(7'h00, 16'h0000);
    rd(7'h02, 16'h002c);
    rd(7'h01, 16'hf67f);
    $display("test soft reset done");
    end_sim;
  end
endmodule : testbench
`default_nettype wire
